//--- hw/ppcm_top.sv
// Purpose: Per-pin drive, care mask, compare, relay and sync pulse logic
// Assumes: Pin inputs synchronous to clock; up to 32 pins on one word
// Notes: Pattern writes apply a word; compare samples pins one cycle later
//
// Functional notes
// - Care bit gates the detector; at 1 actual level is compared to expected.
// - Care bit 0 suppresses the detector output of that pin.
// - Masked pin puts 0 in its result bit and counts as pass.
// - Relay register holds one bit per pin; 1 closes, 0 opens.
// - Computer or manual reset clears pattern, direction, mask, relay, clock registers.
// - Sparse write changes only bits from origin pin for given length.
// - Global comparator enable; outside strobe mode, results reported only for enabled patterns.
// - Strobe mode keeps interim patterns uncompared without enable/disable writes.
// - Four programmable sync pulses fire with each applied pattern word.
// - Direction 1 drives the pin; direction 0 makes it a compared output.
// - Pattern bit sets drive level, or expected value on compared pins.
// - Detector gives 0 on match, 1 on mismatch.
`timescale 1ns/1ps
module ppcm_top #(
  parameter int NUM_PINS = 32
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic manual_reset,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [31:0] rdata,
  input wire logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe,
  output logic [NUM_PINS-1:0] relay,
  output logic [ppcm_pkg::NUM_SYNC-1:0] sync_pulse,
  output logic functional_fail_flag,
  output logic irq
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [NUM_PINS-1:0] dir;
  logic [NUM_PINS-1:0] pat;
  logic [NUM_PINS-1:0] care;
  logic [NUM_PINS-1:0] result;
  logic [NUM_PINS-1:0] det;
  logic [NUM_PINS-1:0] sp_mask;
  logic [NUM_PINS-1:0] sp_data;
  logic [ppcm_pkg::NUM_SYNC-1:0] clk_en;
  logic [2:0] ctrl;
  logic [13:0] sparse;
  logic [ppcm_pkg::NUM_EVENTS-1:0] status;
  logic [ppcm_pkg::NUM_EVENTS-1:0] imask;
  logic [ppcm_pkg::NUM_EVENTS-1:0] next_status;
  logic soft_clear;
  logic wipe;
  logic apply;
  logic apply_strobed;
  logic apply_q;
  logic cmp_q;
  logic [5:0] sp_org;
  logic [6:0] sp_len;

  assign pin_out = pat;
  assign pin_oe = dir;
  assign wipe = manual_reset | soft_clear;
  assign sp_org = sparse[ppcm_pkg::SP_ORG_LSB +: ppcm_pkg::SP_FIELD_W];
  assign sp_len = {1'b0, sparse[ppcm_pkg::SP_LEN_LSB +: ppcm_pkg::SP_FIELD_W]};
  assign apply_strobed = write_strobe && addr == ppcm_pkg::OFF_PAT_STROBE;
  assign apply = write_strobe && (addr == ppcm_pkg::OFF_PAT ||
    addr == ppcm_pkg::OFF_SP_PAT || addr == ppcm_pkg::OFF_PAT_STROBE);

  // ----------------------------------------
  // Sparse write window
  // ----------------------------------------
  // Mask of pins from origin for length
  always_comb begin
    sp_mask = '0;
    for (int i = 0; i < NUM_PINS; i++) begin
      sp_mask[i] = (i >= int'(sp_org)) && (i < int'(sp_org) + int'(sp_len));
    end
    sp_data = NUM_PINS'(wdata << sp_org);
  end

  // Full or windowed update of one pin register
  function automatic logic [NUM_PINS-1:0] upd(input logic [NUM_PINS-1:0] old,
                                              input logic full_hit,
                                              input logic sp_hit,
                                              input logic [31:0] wd,
                                              input logic [NUM_PINS-1:0] msk,
                                              input logic [NUM_PINS-1:0] spd);
    logic [NUM_PINS-1:0] res;
    res = old;
    if (full_hit) begin
      res = wd[NUM_PINS-1:0];
    end else if (sp_hit) begin
      res = (old & ~msk) | (spd & msk);
    end
    return res;
  endfunction

  // ----------------------------------------
  // Pin registers
  // ----------------------------------------
  // Clear on any reset
  always_ff @(posedge clock) begin
    if (reset || wipe) begin
      dir <= ppcm_pkg::RST_REG[NUM_PINS-1:0];
      pat <= ppcm_pkg::RST_REG[NUM_PINS-1:0];
      care <= ppcm_pkg::RST_REG[NUM_PINS-1:0];
      relay <= ppcm_pkg::RST_REG[NUM_PINS-1:0];
      clk_en <= ppcm_pkg::RST_REG[ppcm_pkg::NUM_SYNC-1:0];
    end else if (write_strobe) begin
      dir <= upd(dir, addr == ppcm_pkg::OFF_DIR, addr == ppcm_pkg::OFF_SP_DIR,
                 wdata, sp_mask, sp_data);
      pat <= upd(pat, addr == ppcm_pkg::OFF_PAT || addr == ppcm_pkg::OFF_PAT_STROBE,
                 addr == ppcm_pkg::OFF_SP_PAT, wdata, sp_mask, sp_data);
      care <= upd(care, addr == ppcm_pkg::OFF_CARE, addr == ppcm_pkg::OFF_SP_CARE,
                  wdata, sp_mask, sp_data);
      relay <= upd(relay, addr == ppcm_pkg::OFF_RELAY, addr == ppcm_pkg::OFF_SP_RELAY,
                   wdata, sp_mask, sp_data);
      if (addr == ppcm_pkg::OFF_CLKEN) begin
        clk_en <= wdata[ppcm_pkg::NUM_SYNC-1:0];
      end
    end
  end

  // Control, sparse window and self-clearing wipe
  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl <= ppcm_pkg::RST_CTRL;
      sparse <= ppcm_pkg::RST_SPARSE;
      soft_clear <= 1'b0;
    end else begin
      soft_clear <= write_strobe && addr == ppcm_pkg::OFF_CTRL &&
                    wdata[ppcm_pkg::CTRL_CLEAR];
      if (write_strobe && addr == ppcm_pkg::OFF_CTRL) begin
        ctrl <= {1'b0, wdata[ppcm_pkg::CTRL_STROBE], wdata[ppcm_pkg::CTRL_CMP_EN]};
      end
      if (write_strobe && addr == ppcm_pkg::OFF_SPARSE) begin
        sparse <= wdata[13:0];
      end
    end
  end

  // ----------------------------------------
  // Detector and compare
  // ----------------------------------------
  // Care bit as third detector input
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_det
      assign det[g] = care[g] & ~dir[g] & (pin_in[g] ^ pat[g]);
    end
  endgenerate

  // Strobe mode compares strobed words only
  always_ff @(posedge clock) begin
    if (reset || wipe) begin
      apply_q <= 1'b0;
      cmp_q <= 1'b0;
    end else begin
      apply_q <= apply;
      cmp_q <= apply && (ctrl[ppcm_pkg::CTRL_STROBE] ? apply_strobed :
                         ctrl[ppcm_pkg::CTRL_CMP_EN]);
    end
  end

  // Masked pins load 0 into results
  always_ff @(posedge clock) begin
    if (reset || wipe) begin
      result <= ppcm_pkg::RST_REG[NUM_PINS-1:0];
      functional_fail_flag <= 1'b0;
    end else if (apply_q && cmp_q) begin
      result <= det;
      functional_fail_flag <= |det;
    end
  end

  // Sync pulses with each applied word
  always_ff @(posedge clock) begin
    if (reset || wipe) begin
      sync_pulse <= '0;
    end else begin
      sync_pulse <= apply ? clk_en : '0;
    end
  end

  // ----------------------------------------
  // Interrupt status and mask
  // ----------------------------------------
  // Sticky events, set wins over write-one clear
  always_comb begin
    next_status = status;
    if (write_strobe && addr == ppcm_pkg::OFF_STATUS) begin
      next_status = status & ~wdata[ppcm_pkg::NUM_EVENTS-1:0];
    end
    if (apply_q && cmp_q) begin
      next_status[ppcm_pkg::ST_DONE] = 1'b1;
      if (|det) begin
        next_status[ppcm_pkg::ST_FAIL] = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      status <= '0;
      imask <= '0;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      irq <= |(next_status & imask);
      if (write_strobe && addr == ppcm_pkg::OFF_IMASK) begin
        imask <= wdata[ppcm_pkg::NUM_EVENTS-1:0];
      end
    end
  end

  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  // Data in the cycle after the read strobe only
  always_ff @(posedge clock) begin
    if (reset || !read_strobe) begin
      rdata <= 32'h0000_0000;
    end else begin
      case (addr)
        ppcm_pkg::OFF_DIR: rdata <= 32'(dir);
        ppcm_pkg::OFF_PAT: rdata <= 32'(pat);
        ppcm_pkg::OFF_CARE: rdata <= 32'(care);
        ppcm_pkg::OFF_RELAY: rdata <= 32'(relay);
        ppcm_pkg::OFF_CLKEN: rdata <= 32'(clk_en);
        ppcm_pkg::OFF_CTRL: rdata <= 32'(ctrl);
        ppcm_pkg::OFF_SPARSE: rdata <= 32'(sparse);
        ppcm_pkg::OFF_RESULT: rdata <= 32'(result);
        ppcm_pkg::OFF_STATUS: rdata <= 32'(status);
        ppcm_pkg::OFF_IMASK: rdata <= 32'(imask);
        default: rdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_cmp_apply;
    apply_q && cmp_q && !wipe;
  endsequence

  sequence s_any_apply;
    apply && !wipe;
  endsequence

  property p_care_detect;
    s_cmp_apply |=> result == ($past(care) & ~$past(pin_oe) & ($past(pin_in) ^ $past(pin_out)));
  endproperty
  a_care_detect: assert property (p_care_detect) else $error("result not loaded");

  property p_mask_zero;
    s_cmp_apply |=> (result & ~$past(care)) == '0;
  endproperty
  a_mask_zero: assert property (p_mask_zero) else $error("masked pin failed");

  property p_mismatch;
    s_cmp_apply ##0 (det != '0) |=> functional_fail_flag && status[ppcm_pkg::ST_FAIL];
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("mismatch not flagged");

  property p_no_cmp_hold;
    apply_q && !cmp_q && !wipe |=> $stable(result) && $stable(functional_fail_flag);
  endproperty
  a_no_cmp_hold: assert property (p_no_cmp_hold) else $error("result changed");

  property p_strobe_interim;
    s_any_apply ##0 (ctrl[ppcm_pkg::CTRL_STROBE] && !apply_strobed) |=> !cmp_q;
  endproperty
  a_strobe_interim: assert property (p_strobe_interim) else $error("interim compared");

  property p_sync;
    s_any_apply |=> sync_pulse == $past(clk_en) ##1 ($past(apply) || sync_pulse == '0);
  endproperty
  a_sync: assert property (p_sync) else $error("sync pulse wrong");

  property p_clear;
    manual_reset |=> dir == '0 && pat == '0 && care == '0 && relay == '0 && clk_en == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("registers not cleared");

  property p_sparse;
    write_strobe && addr == ppcm_pkg::OFF_SP_PAT && !wipe
      |=> ((pat ^ $past(pat)) & ~$past(sp_mask)) == '0;
  endproperty
  a_sparse: assert property (p_sparse) else $error("sparse write leaked");

  property p_dir_drive;
    write_strobe && addr == ppcm_pkg::OFF_DIR && !wipe
      |=> pin_oe == $past(wdata[NUM_PINS-1:0]);
  endproperty
  a_dir_drive: assert property (p_dir_drive) else $error("drive enable wrong");

  property p_relay;
    write_strobe && addr == ppcm_pkg::OFF_RELAY && !wipe
      |=> relay == $past(wdata[NUM_PINS-1:0])
          ##1 ($past(write_strobe) || $past(wipe) || $stable(relay));
  endproperty
  a_relay: assert property (p_relay) else $error("relay not held");

endmodule

//--- hw/ppcm_pkg.sv
// Purpose: Constants for the per-pin pattern, compare and mask block
// Assumes: 32-bit register port, byte addresses, one word per register
// Notes: All offsets, field positions and reset values live here
package ppcm_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_DIR = 8'h00;
  localparam logic [7:0] OFF_PAT = 8'h04;
  localparam logic [7:0] OFF_CARE = 8'h08;
  localparam logic [7:0] OFF_RELAY = 8'h0C;
  localparam logic [7:0] OFF_CLKEN = 8'h10;
  localparam logic [7:0] OFF_CTRL = 8'h14;
  localparam logic [7:0] OFF_SPARSE = 8'h18;
  localparam logic [7:0] OFF_SP_DIR = 8'h20;
  localparam logic [7:0] OFF_SP_PAT = 8'h24;
  localparam logic [7:0] OFF_SP_CARE = 8'h28;
  localparam logic [7:0] OFF_SP_RELAY = 8'h2C;
  localparam logic [7:0] OFF_PAT_STROBE = 8'h30;
  localparam logic [7:0] OFF_RESULT = 8'h34;
  localparam logic [7:0] OFF_STATUS = 8'h38;
  localparam logic [7:0] OFF_IMASK = 8'h3C;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_CMP_EN = 0;
  localparam int CTRL_STROBE = 1;
  localparam int CTRL_CLEAR = 2;
  localparam int SP_ORG_LSB = 0;
  localparam int SP_LEN_LSB = 8;
  localparam int SP_FIELD_W = 6;
  localparam int ST_FAIL = 0;
  localparam int ST_DONE = 1;
  localparam int NUM_SYNC = 4;
  localparam int NUM_EVENTS = 2;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [31:0] RST_REG = 32'h0000_0000;
  localparam logic [2:0] RST_CTRL = 3'h0;
  localparam logic [13:0] RST_SPARSE = 14'h0000;
endpackage

//--- tb/ppcm_pin_model.sv
// Purpose: Device under test as seen from the tester pins
// Assumes: Driven pins loop back, compared pins show a set response
// Notes: Combinational, answers within the same cycle
`timescale 1ns/1ps
module ppcm_pin_model #(
  parameter int NUM_PINS = 32
) (
  input wire logic [NUM_PINS-1:0] pin_out,
  input wire logic [NUM_PINS-1:0] pin_oe,
  input wire logic [NUM_PINS-1:0] resp,
  output logic [NUM_PINS-1:0] pin_in
);
  // Driven pins echo the drive level, outputs show the response
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & resp);
endmodule

//--- tb/tb_top.sv
// Purpose: Self-checking bench for the pin pattern compare block
// Assumes: One clock, register port with one-cycle strobes
// Notes: Each scenario task judges its own checks; later tasks build on state left by earlier ones
`timescale 1ns/1ps
module tb_top;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic manual_reset = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic write_strobe = 1'b0;
  logic read_strobe = 1'b0;
  logic [31:0] rdata;
  logic [31:0] pin_in, pin_out, pin_oe, relay;
  logic [31:0] resp = 32'h0000_0000;
  logic [ppcm_pkg::NUM_SYNC-1:0] sync_pulse;
  logic functional_fail_flag, irq;
  logic [31:0] rv;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;

  // Clock, 100 ns period
  always #50 clock = ~clock;

  ppcm_top u_dut (.clock(clock), .reset(reset), .manual_reset(manual_reset), .addr(addr),
    .wdata(wdata), .write_strobe(write_strobe), .read_strobe(read_strobe), .rdata(rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .relay(relay),
    .sync_pulse(sync_pulse), .functional_fail_flag(functional_fail_flag), .irq(irq));
  ppcm_pin_model u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .resp(resp), .pin_in(pin_in));

  // ----------------------------------------
  // Bus and check helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    addr <= a;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1 rv = rdata;
  endtask
  task automatic step();
    @(posedge clock);
    #1;
  endtask
  // Apply one word against a response, then judge result and flag
  task automatic apply(input logic [7:0] a, input logic [31:0] p, input logic [31:0] r,
                       input logic [31:0] res, input logic fl);
    @(posedge clock);
    resp <= r;
    wr(a, p);
    step();
    rd(ppcm_pkg::OFF_RESULT);
    chk("result", res, rv);
    chk("fail flag", {31'h0, fl}, {31'h0, functional_fail_flag});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 5; i++) begin
      rd(ppcm_pkg::OFF_DIR + 8'(4 * i));
      chk("reset reg", ppcm_pkg::RST_REG, rv);
    end
    rd(8'h40);
    chk("unmapped", 32'h0000_0000, rv);
    chk("pin_out", 32'h0000_0000, pin_out);
    chk("relay", 32'h0000_0000, relay);
  endtask
  task automatic t_relay();
    wr(ppcm_pkg::OFF_RELAY, 32'hA5A5_0F0F);
    #1 chk("relay", 32'hA5A5_0F0F, relay);
  endtask
  task automatic t_compare();
    wr(ppcm_pkg::OFF_DIR, 32'h0000_00FF);
    #1 chk("pin_oe", 32'h0000_00FF, pin_oe);
    wr(ppcm_pkg::OFF_CARE, 32'h0000_0FFF);
    wr(ppcm_pkg::OFF_CTRL, 32'h0000_0001);
    apply(ppcm_pkg::OFF_PAT, 32'h0000_015A, 32'h0010_0200, 32'h0000_0300, 1'b1);
    chk("pin_out", 32'h0000_015A, pin_out);
    apply(ppcm_pkg::OFF_PAT, 32'h0000_015A, 32'h0010_0300, 32'h0000_0200, 1'b1);
    apply(ppcm_pkg::OFF_PAT, 32'h0000_015A, 32'h0010_0100, 32'h0000_0000, 1'b0);
  endtask
  task automatic t_enable();
    wr(ppcm_pkg::OFF_CTRL, 32'h0000_0000);
    apply(ppcm_pkg::OFF_PAT, 32'h0000_015A, 32'h0000_0200, 32'h0000_0000, 1'b0);
    wr(ppcm_pkg::OFF_CTRL, 32'h0000_0002);
    apply(ppcm_pkg::OFF_PAT, 32'h0000_015A, 32'h0000_0200, 32'h0000_0000, 1'b0);
    apply(ppcm_pkg::OFF_PAT_STROBE, 32'h0000_015A, 32'h0000_0200, 32'h0000_0300, 1'b1);
  endtask
  task automatic t_sync();
    logic [3:0] v;
    for (int i = 0; i < 5; i++) begin
      v = (i < 4) ? 4'(1 << i) : 4'hF;
      wr(ppcm_pkg::OFF_CLKEN, {28'h0, v});
      wr(ppcm_pkg::OFF_PAT, 32'h0000_015A);
      #1 chk("sync", {28'h0, v}, {28'h0, sync_pulse});
      step();
      chk("sync end", 32'h0000_0000, {28'h0, sync_pulse});
    end
  endtask
  task automatic t_sparse();
    wr(ppcm_pkg::OFF_PAT, 32'hFFFF_0000);
    wr(ppcm_pkg::OFF_SPARSE, 32'h0000_0206);
    wr(ppcm_pkg::OFF_SP_PAT, 32'h0000_0002);
    #1 chk("sparse mid", 32'hFFFF_0080, pin_out);
    wr(ppcm_pkg::OFF_SPARSE, 32'h0000_041E);
    wr(ppcm_pkg::OFF_SP_PAT, 32'h0000_0005);
    #1 chk("sparse top", 32'h7FFF_0080, pin_out);
    wr(ppcm_pkg::OFF_SPARSE, 32'h0000_0003);
    wr(ppcm_pkg::OFF_SP_PAT, 32'hFFFF_FFFF);
    #1 chk("sparse len0", 32'h7FFF_0080, pin_out);
    wr(ppcm_pkg::OFF_SPARSE, 32'h0000_0404);
    wr(ppcm_pkg::OFF_SP_RELAY, 32'h0000_000F);
    wr(ppcm_pkg::OFF_SP_DIR, 32'h0000_0000);
    wr(ppcm_pkg::OFF_SP_CARE, 32'h0000_0005);
    #1 chk("sparse relay", 32'hA5A5_0FFF, relay);
    chk("sparse dir", 32'h0000_000F, pin_oe);
    rd(ppcm_pkg::OFF_CARE);
    chk("sparse care", 32'h0000_0F5F, rv);
    rd(ppcm_pkg::OFF_SPARSE);
    chk("sparse reg", 32'h0000_0404, rv);
  endtask
  task automatic t_irq();
    rd(ppcm_pkg::OFF_STATUS);
    chk("status", 32'h0000_0003, rv);
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    wr(ppcm_pkg::OFF_IMASK, 32'h0000_0001);
    step();
    chk("irq", 32'h0000_0001, {31'h0, irq});
    wr(ppcm_pkg::OFF_STATUS, 32'h0000_0001);
    step();
    step();
    chk("irq cleared", 32'h0000_0000, {31'h0, irq});
    rd(ppcm_pkg::OFF_STATUS);
    chk("status w1c", 32'h0000_0002, rv);
  endtask
  task automatic t_wipe();
    @(posedge clock);
    manual_reset <= 1'b1;
    @(posedge clock);
    manual_reset <= 1'b0;
    #1 chk("wipe pat", 32'h0000_0000, pin_out);
    chk("wipe relay", 32'h0000_0000, relay);
    chk("wipe flag", 32'h0000_0000, {31'h0, functional_fail_flag});
    wr(ppcm_pkg::OFF_DIR, 32'h0000_1234);
    wr(ppcm_pkg::OFF_CTRL, 32'h0000_0004);
    step();
    chk("soft wipe", 32'h0000_0000, pin_oe);
  endtask

  // ----------------------------------------
  // Verdict, timeout and main sequence
  // ----------------------------------------
  task automatic summarize();
    $display("error_cnt %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Cut a hang short
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      error_cnt++;
      summarize();
    end
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    t_reset();
    t_relay();
    t_compare();
    t_enable();
    t_sync();
    t_sparse();
    t_irq();
    t_wipe();
    summarize();
  end
endmodule
